// ==== core/rdr_top.sv ====
// Rotated display refresh: APB registers, scan timing and address generation
`timescale 1ns/1ns
`include "rdr_consts.svh"
module rdr_top #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [ADDR_W-1:0] memAddr,
  output logic                   memRead,
  output logic                   pixValid,
  output logic                   lineStart,
  output logic                   frameStart,
  output logic                   rotActive
);
  rdr_pkg::rdr_scan_t state_q;
  rdr_pkg::rdr_scan_t state_d;

  logic [7:0] mode1_q;
  logic [7:0] hblank_q;
  logic [7:0] vblank_q;
  logic [7:0] startLo_q;
  logic [7:0] startHi_q;
  logic [7:0] rotMode_q;
  logic [7:0] stride_q;
  logic [7:0] dispW_q;
  logic [7:0] dispH_q;

  logic [9:0] hCnt_q;
  logic [9:0] hCnt_d;
  logic [9:0] vCnt_q;
  logic [9:0] vCnt_d;
  logic [ADDR_W-1:0] lineBase_q;
  logic [ADDR_W-1:0] lineBase_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [15:0] frameCnt_q;

  wire        pixTick;
  wire        access    = psel && penable;
  wire        wrStrobe  = access && pwrite;
  wire [7:0]  regIdx    = paddr[9:2];
  wire        aligned   = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
  wire        selMode1  = aligned && regIdx == `RDR_IDX_MODE1;
  wire        selHblank = aligned && regIdx == `RDR_IDX_HBLANK;
  wire        selVblank = aligned && regIdx == `RDR_IDX_VBLANK;
  wire        selStLo   = aligned && regIdx == `RDR_IDX_START_LO;
  wire        selStHi   = aligned && regIdx == `RDR_IDX_START_HI;
  wire        selRot    = aligned && regIdx == `RDR_IDX_ROT_MODE;
  wire        selStride = aligned && regIdx == `RDR_IDX_STRIDE;
  wire        selDispW  = aligned && regIdx == `RDR_IDX_DISP_W;
  wire        selDispH  = aligned && regIdx == `RDR_IDX_DISP_H;
  wire        selStatus = aligned && regIdx == `RDR_IDX_STATUS;
  wire        hit       = selMode1 | selHblank | selVblank | selStLo | selStHi | selRot
                          | selStride | selDispW | selDispH | selStatus;

  wire        rotEn     = rotMode_q[`RDR_ROT_EN_BIT];
  wire        altSel    = rotEn && rotMode_q[`RDR_ROT_SEL_BIT];
  // Start address: byte offset when rotated, word offset in landscape
  wire [14:0] startRaw  = {startHi_q[6:0], startLo_q};
  wire [ADDR_W-1:0] startByte = rotEn ? ADDR_W'(startRaw)
                                      : ADDR_W'({startRaw, 1'b0});
  // Default scheme pans in pairs of lines: stride low bit dropped for the odd-line half offset
  wire [ADDR_W-1:0] strideEff = rotEn ? ADDR_W'(stride_q)
                                      : ADDR_W'(dispW_q);
  wire [9:0]  hTotal    = {2'b00, dispW_q} + {2'b00, hblank_q};
  wire [9:0]  vTotal    = {2'b00, dispH_q} + {2'b00, vblank_q};
  wire        hLast     = hCnt_q == hTotal - 10'd1;
  wire        vLast     = vCnt_q == vTotal - 10'd1;
  wire        inDisp    = hCnt_q < {2'b00, dispW_q} && vCnt_q < {2'b00, dispH_q};
  wire        pairStep  = !altSel && rotEn;
  wire        stepLine  = !pairStep || vCnt_q[0];
  wire [ADDR_W-1:0] pairOff = (pairStep && !vCnt_q[0]) ? ADDR_W'(stride_q >> 1)
                                                        : '0;

  wire [31:0] rdMode1   = {24'h000000, mode1_q};
  wire [31:0] rdHblank  = {24'h000000, hblank_q};
  wire [31:0] rdVblank  = {24'h000000, vblank_q};
  wire [31:0] rdStLo    = {24'h000000, startLo_q};
  wire [31:0] rdStHi    = {24'h000000, 1'b0, startHi_q[6:0]};
  wire [31:0] rdRot     = {24'h000000, rotMode_q[7:6], 3'b000, 1'b0, rotMode_q[1:0]};
  wire [31:0] rdStride  = {24'h000000, stride_q};
  wire [31:0] rdDispW   = {24'h000000, dispW_q};
  wire [31:0] rdDispH   = {24'h000000, dispH_q};
  wire [31:0] rdStatus  = {frameCnt_q, 6'h00, vCnt_q};
  wire [31:0] rdMux     = selMode1  ? rdMode1  :
                          selHblank ? rdHblank :
                          selVblank ? rdVblank :
                          selStLo   ? rdStLo   :
                          selStHi   ? rdStHi   :
                          selRot    ? rdRot    :
                          selStride ? rdStride :
                          selDispW  ? rdDispW  :
                          selDispH  ? rdDispH  :
                          selStatus ? rdStatus : 32'h00000000;

  wire        setupPh   = psel && !penable;
  wire        rdSetup   = setupPh && !pwrite;
  wire        wrMode1   = wrStrobe && selMode1;
  wire        wrHblank  = wrStrobe && selHblank;
  wire        wrVblank  = wrStrobe && selVblank;
  wire        wrStLo    = wrStrobe && selStLo;
  wire        wrStHi    = wrStrobe && selStHi;
  wire        wrRot     = wrStrobe && selRot;
  wire        wrStride  = wrStrobe && selStride;
  wire        wrDispW   = wrStrobe && selDispW;
  wire        wrDispH   = wrStrobe && selDispH;

  // Fetch address only moves together with its pixel strobe
  wire        scanOn    = state_q != rdr_pkg::RDR_IDLE;
  wire        pixFire   = pixTick && inDisp && scanOn;
  wire        lineFire  = pixTick && hCnt_q == 10'd0 && scanOn;
  wire        frameFire = lineFire && vCnt_q == 10'd0;
  wire        frameEnd  = pixTick && hLast && vLast;

  rdr_clk_div u_div (
    .clock     (clock),
    .rst_b     (rst_b),
    .inDivTwo  (mode1_q[`RDR_INDIV_BIT]),
    .rotEnable (rotEn),
    .altScheme (altSel),
    .pclkSel   (rotMode_q[1:0]),
    .pixTick   (pixTick)
  );

  always_comb begin
    state_d    = state_q;
    hCnt_d     = hCnt_q;
    vCnt_d     = vCnt_q;
    lineBase_d = lineBase_q;
    addr_d     = addr_q;
    case (state_q)
      rdr_pkg::RDR_IDLE: begin
        if (pixTick) begin
          state_d    = rdr_pkg::RDR_PIXEL;
          hCnt_d     = 10'd0;
          vCnt_d     = 10'd0;
          lineBase_d = startByte;
          addr_d     = startByte;
        end
      end
      rdr_pkg::RDR_PIXEL, rdr_pkg::RDR_HBLK, rdr_pkg::RDR_VBLK: begin
        if (pixTick) begin
          if (hLast) begin
            hCnt_d = 10'd0;
            if (vLast) begin
              vCnt_d     = 10'd0;
              lineBase_d = startByte;
              addr_d     = startByte;
              state_d    = rdr_pkg::RDR_PIXEL;
            end else begin
              vCnt_d     = vCnt_q + 10'd1;
              lineBase_d = stepLine ? lineBase_q + strideEff : lineBase_q;
              addr_d     = (stepLine ? lineBase_q + strideEff : lineBase_q)
                           + (pairStep && vCnt_q[0] ? '0 : pairOff);
              state_d    = (vCnt_q + 10'd1 < {2'b00, dispH_q}) ? rdr_pkg::RDR_PIXEL
                                                               : rdr_pkg::RDR_VBLK;
            end
          end else begin
            hCnt_d  = hCnt_q + 10'd1;
            addr_d  = inDisp ? addr_q + ADDR_W'(1) : addr_q;
            state_d = (hCnt_q + 10'd1 >= {2'b00, dispW_q}) ? rdr_pkg::RDR_HBLK : state_q;
          end
        end
      end
      default: begin
        state_d = rdr_pkg::RDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode1_q <= `RDR_RST_BYTE;
    end else if (wrMode1) begin
      mode1_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hblank_q <= `RDR_RST_BYTE;
    end else if (wrHblank) begin
      hblank_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      vblank_q <= `RDR_RST_BYTE;
    end else if (wrVblank) begin
      vblank_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      startLo_q <= `RDR_RST_BYTE;
    end else if (wrStLo) begin
      startLo_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      startHi_q <= `RDR_RST_BYTE;
    end else if (wrStHi) begin
      startHi_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rotMode_q <= `RDR_RST_BYTE;
    end else if (wrRot) begin
      rotMode_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stride_q <= `RDR_RST_BYTE;
    end else if (wrStride) begin
      stride_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dispW_q <= `RDR_RST_DISP_W;
    end else if (wrDispW) begin
      dispW_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dispH_q <= `RDR_RST_DISP_H;
    end else if (wrDispH) begin
      dispH_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPh;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPh && !hit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= rdSetup ? rdMux : 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q    <= rdr_pkg::RDR_IDLE;
      hCnt_q     <= 10'd0;
      vCnt_q     <= 10'd0;
      lineBase_q <= '0;
      addr_q     <= '0;
    end else begin
      state_q    <= state_d;
      hCnt_q     <= hCnt_d;
      vCnt_q     <= vCnt_d;
      lineBase_q <= lineBase_d;
      addr_q     <= addr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      frameCnt_q <= 16'h0000;
    end else if (frameEnd) begin
      frameCnt_q <= frameCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      memAddr <= '0;
    end else if (pixFire) begin
      memAddr <= addr_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      memRead    <= 1'b0;
      pixValid   <= 1'b0;
      lineStart  <= 1'b0;
      frameStart <= 1'b0;
      rotActive  <= 1'b0;
    end else begin
      memRead    <= pixFire;
      pixValid   <= pixFire;
      lineStart  <= lineFire;
      frameStart <= frameFire;
      rotActive  <= rotEn;
    end
  end
endmodule

// ==== core/rdr_consts.svh ====
// Register offsets, field positions, reset values and clock rates for the rotated refresh block
`ifndef RDR_CONSTS_SVH
`define RDR_CONSTS_SVH

`define RDR_IDX_MODE1      8'h02
`define RDR_IDX_HBLANK     8'h08
`define RDR_IDX_VBLANK     8'h0a
`define RDR_IDX_START_LO   8'h0c
`define RDR_IDX_START_HI   8'h0d
`define RDR_IDX_ROT_MODE   8'h1b
`define RDR_IDX_STRIDE     8'h1c
`define RDR_IDX_DISP_W     8'h20
`define RDR_IDX_DISP_H     8'h21
`define RDR_IDX_STATUS     8'h22

`define RDR_ROT_EN_BIT     7
`define RDR_ROT_SEL_BIT    6
`define RDR_INDIV_BIT      4

`define RDR_RST_BYTE       8'h00
`define RDR_RST_DISP_W     8'h10
`define RDR_RST_DISP_H     8'h10

`define RDR_CLK_MAX_MHZ    25
`define RDR_CLK_MHZ        100

`endif

// ==== core/rdr_pkg.sv ====
// Types shared by the rotated refresh block
package rdr_pkg;
  typedef enum logic [3:0] {
    RDR_IDLE  = 4'b0001,
    RDR_PIXEL = 4'b0010,
    RDR_HBLK  = 4'b0100,
    RDR_VBLK  = 4'b1000
  } rdr_scan_t;
endpackage

// ==== core/rdr_clk_div.sv ====
// Pixel tick divider derived from the operating clock
`timescale 1ns/1ns
module rdr_clk_div (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       inDivTwo,
  input  wire logic       rotEnable,
  input  wire logic       altScheme,
  input  wire logic [1:0] pclkSel,
  output logic            pixTick
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] limit;
  logic [2:0] shift;
  // Rotation off: pixel rate equals operating rate, or half of it with inDivTwo set
  assign shift = !rotEnable ? 3'd0 : {1'b0, pclkSel} + {2'b00, altScheme};
  assign limit = (5'd1 << ({2'b00, shift} + {4'b0000, inDivTwo})) - 5'd1;
  assign cnt_d = (cnt_q >= limit) ? 5'd0 : cnt_q + 5'd1;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_q   <= 5'd0;
      pixTick <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pixTick <= (cnt_q >= limit);
    end
  end
endmodule

// ==== tb/rdr_top_chk.sv ====
// Port checker for the rotated refresh block
`timescale 1ns/1ns
module rdr_top_chk #(parameter int ADDR_W = 16) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic              memRead,
  input wire logic              pixValid,
  input wire logic              lineStart,
  input wire logic              frameStart,
  input wire logic              rotActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_rot;
    (pready && pwrite && !pslverr && paddr == 12'h06c)
      |-> ##2 rotActive == $past(pwdata[7], 2);
  endproperty
  a_ready_after_setup: assert property (s_setup |=> s_access) else $error("No answer after setup");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("Stray ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("Ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("Error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("Read data not zero");
  a_fetch_is_pixel: assert property (memRead == pixValid) else $error("Fetch and pixel differ");
  a_frame_starts_line: assert property (frameStart |-> lineStart && pixValid)
    else $error("Bad frame start");
  a_rot_follows_bit: assert property (p_rot)
    else $error("Rotation flag wrong");
  a_addr_moves_pixel: assert property ($changed(memAddr) |-> pixValid)
    else $error("Address moved idle");
endmodule
bind rdr_top rdr_top_chk #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .memAddr(memAddr), .memRead(memRead), .pixValid(pixValid),
  .lineStart(lineStart), .frameStart(frameStart), .rotActive(rotActive));

// ==== tb/rdr_panel_model.sv ====
// Panel model that measures each refreshed frame
`timescale 1ns/1ns
module rdr_panel_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] memAddr,
  input  wire logic        pixValid,
  input  wire logic        lineStart,
  input  wire logic        frameStart,
  output int               period,
  output int               pixels,
  output int               frames,
  output logic      [15:0] firstAddr,
  output logic      [15:0] line2Addr
);
  int cyc = 0, lastCyc = 0, pixCnt = 0, lineCnt = 0;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (!rst_b) begin
      frames <= 0;
      period <= 0;
      pixels <= 0;
    end else if (frameStart === 1'b1) begin
      period <= cyc - lastCyc;
      lastCyc <= cyc;
      pixels <= pixCnt;
      pixCnt <= 1;
      lineCnt <= 1;
      frames <= frames + 1;
      firstAddr <= memAddr;
    end else begin
      if (pixValid === 1'b1) pixCnt <= pixCnt + 1;
      if (lineStart === 1'b1 && lineCnt == 1) line2Addr <= memAddr;
      if (lineStart === 1'b1) lineCnt <= lineCnt + 1;
    end
  end
endmodule

// ==== tb/tb_rdr_top.sv ====
// Self-checking bench for the rotated refresh block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_rdr_top;
  logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, memRead, pixValid, lineStart, frameStart, rotActive;
  logic [15:0] memAddr, firstAddr, line2Addr;
  int          period, pixels, frames, n_fail = 0, comparisons = 0, k;
  logic [7:0]  rot [5] = '{8'h40, 8'h80, 8'hc0, 8'hc1, 8'h80};
  logic [7:0]  md [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
  logic [7:0]  str [5] = '{8'h78, 8'h80, 8'h78, 8'h78, 8'h80};
  int          per [5] = '{306, 306, 612, 1224, 612};
  logic [15:0] fa [5] = '{16'h00ee, 16'h0077, 16'h0077, 16'h0077, 16'h0077};
  rdr_top #(.ADDR_W(16)) DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memAddr(memAddr), .memRead(memRead), .pixValid(pixValid),
    .lineStart(lineStart), .frameStart(frameStart), .rotActive(rotActive));
  rdr_panel_model u_panel (.clock(clock), .rst_b(rst_b), .memAddr(memAddr), .pixValid(pixValid),
    .lineStart(lineStart), .frameStart(frameStart), .period(period), .pixels(pixels),
    .frames(frames), .firstAddr(firstAddr), .line2Addr(line2Addr));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic stop_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  task automatic wait_frames();
    int f;
    f = frames;
    while (frames < f + 3) @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(12'h088, 32'h0);
    rd(12'h070, 32'h0);
    rd(12'h080, 32'h10);
    rd(12'h0fc, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, 12'h020, 32'h2);
    apb(1'b1, 12'h028, 32'h1);
    apb(1'b1, 12'h030, 32'h77);
    apb(1'b1, 12'h034, 32'h0);
    apb(1'b1, 12'h070, 32'h78);
    rd(12'h070, 32'h78);
    for (k = 0; k < 5; k++) begin
      apb(1'b1, 12'h070, {24'h0, str[k]});
      apb(1'b1, 12'h008, {24'h0, md[k]});
      apb(1'b1, 12'h06c, {24'h0, rot[k]});
      rd(12'h06c, {24'h0, rot[k]});
      wait_frames();
      `CHK(rotActive, rot[k][7])
      `CHK(period, per[k])
      `CHK(pixels, 256)
      `CHK(firstAddr, fa[k])
      if (k == 2) `CHK(line2Addr, 16'h00ef)
    end
    stop_test();
  end
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule
